// File: hw/can_rx_acceptance_filter.sv
// receive acceptance filter with avalon register slave
`default_nettype none
module can_rx_acceptance_filter
  import can_rx_filter_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        idValid,
  input  wire rxFrame_t    rxFrame,
  input  wire logic        dataValid,
  input  wire logic [31:0] dataWord,
  input  wire logic        frameEnd,
  input  wire logic        frameErr,
  input  wire logic        dataPhaseErr,
  input  wire logic [2:0]  errCode,
  output ramWrite_t        ramWrite,
  output logic             fifoPut0,
  output logic             fifoPut1,
  output logic             filterEvent,
  output logic             highPriorityMsgFlag,
  output logic             busy
);
  logic [3:0]         globalFilterConfig_q;
  logic [3:0]         stdListConfig_q;
  logic [3:0]         extListConfig_q;
  logic [28:0]        extIdentifierAndMask_q;
  logic [31:0]        stdElem_q [STD_ELEMS];
  logic [31:0]        extElem_q [2*EXT_ELEMS];
  logic [RX_BUFS-1:0] newData_q;
  logic [RX_BUFS-1:0] newData_d;
  logic [2:0]         lastErrorCode_q;
  logic [2:0]         dataPhaseLastErrorCode_q;
  logic               hpm_q;
  logic               waitReq_q;
  logic [31:0]        readData_q;
  state_t             state_q;
  state_t             state_d;
  rxFrame_t           frame_q;
  logic [3:0]         elemIdx_q;
  tgt_t               tgt_q;
  logic [4:0]         bufIdx_q;
  logic [4:0]         word_q;
  ramWrite_t          ramWrite_q;
  logic               put0_q;
  logic               put1_q;
  logic               event_q;
  logic               busy_q;

  // bus decode: one wait cycle, then the access completes
  logic        busReq;
  logic        wrEn;
  logic [31:0] wrMask;
  logic [5:0]  wordAddr;
  logic        selStd;
  logic        selExt;
  logic [31:0] rdMux;
  logic [31:0] statusWord;

  assign busReq     = read | write;
  assign wrEn       = write & ~waitReq_q;
  assign wrMask     = beMask(byteenable);
  assign wordAddr   = address[7:2];
  assign selStd     = address[7:5] == STD_ELEM_BASE;
  assign selExt     = address[7:6] == EXT_ELEM_BASE;
  assign statusWord = {22'h00_0000, ~state_q[0], hpm_q, 1'b0, dataPhaseLastErrorCode_q,
                       1'b0, lastErrorCode_q};
  assign rdMux = selStd ? stdElem_q[address[4:2]] :
                 selExt ? extElem_q[address[5:2]] :
                 (wordAddr == REG_GLOBAL_CFG[7:2]) ? {28'h000_0000, globalFilterConfig_q} :
                 (wordAddr == REG_STD_LIST[7:2])   ? {28'h000_0000, stdListConfig_q} :
                 (wordAddr == REG_EXT_LIST[7:2])   ? {28'h000_0000, extListConfig_q} :
                 (wordAddr == REG_EXT_MASK[7:2])   ? {3'h0, extIdentifierAndMask_q} :
                 (wordAddr == REG_STATUS[7:2])     ? statusWord :
                 (wordAddr == REG_NEW_DATA[7:2])   ? newData_q : 32'h0000_0000;

  // current element fields; the list follows the frame's ide bit
  logic        isExt;
  logic [3:0]  listLen;
  logic        listEnd;
  logic [31:0] curStd;
  logic [31:0] curExtA;
  logic [31:0] curExtB;
  act_t        action;
  logic [1:0]  fType;
  logic [28:0] idOne;
  logic [28:0] idTwo;
  logic [28:0] idMasked;
  logic [4:0]  elemBuf;
  logic        typeHit;
  logic        elemHit;
  logic [1:0]  noMatchCfg;
  tgt_t        decTgt;
  logic        decide;
  logic        setHpm;

  assign isExt   = frame_q.ide;
  assign listLen = isExt ? extListConfig_q : stdListConfig_q;
  assign listEnd = (elemIdx_q >= listLen) || (elemIdx_q >= 4'(STD_ELEMS));
  assign curStd  = stdElem_q[elemIdx_q[2:0]];
  assign curExtA = extElem_q[{elemIdx_q[2:0], 1'b0}];
  assign curExtB = extElem_q[{elemIdx_q[2:0], 1'b1}];
  assign action  = act_t'(isExt ? curExtA[EXT_ACT +: 3] : curStd[STD_ACT +: 3]);
  assign fType   = isExt ? curExtB[EXT_TYPE +: 2] : curStd[STD_TYPE +: 2];
  assign idOne   = isExt ? curExtA[28:0] : {18'h0_0000, curStd[STD_ID1 +: 11]};
  assign idTwo   = isExt ? curExtB[28:0] : {18'h0_0000, curStd[10:0]};
  assign idMasked = isExt ? (frame_q.id & extIdentifierAndMask_q) : frame_q.id;
  assign elemBuf = idTwo[4:0];

  can_rx_elem_match elemMatch (
    .filterType (fType),
    .isExt      (isExt),
    .idOne      (idOne),
    .idTwo      (idTwo),
    .idMasked   (idMasked),
    .idRaw      (frame_q.id),
    .hit        (typeHit)
  );

  // a buffer still holding unread data lets the walk go on
  assign elemHit = ~listEnd && (action != ACT_DISABLED) &&
                   ((action == ACT_RXBUF) ? (idMasked == idOne && !newData_q[elemBuf]) :
                    typeHit);
  assign decide     = state_q[1] && (elemHit || listEnd);
  assign noMatchCfg = isExt ? globalFilterConfig_q[NM_EXT +: 2] : globalFilterConfig_q[1:0];
  assign decTgt = !elemHit ? ((noMatchCfg == NM_FIFO0) ? TGT_FIFO0 :
                              (noMatchCfg == NM_FIFO1) ? TGT_FIFO1 : TGT_NONE) :
                  (action == ACT_FIFO0 || action == ACT_HPM_FIFO0) ? TGT_FIFO0 :
                  (action == ACT_FIFO1 || action == ACT_HPM_FIFO1) ? TGT_FIFO1 :
                  (action == ACT_RXBUF) ? TGT_RXBUF : TGT_NONE;
  assign setHpm = decide && elemHit &&
                  (action == ACT_HPM || action == ACT_HPM_FIFO0 || action == ACT_HPM_FIFO1);

  // frame sequencing; identifiers are taken only while idle
  logic frameDone;
  logic goodEnd;

  assign frameDone = frameEnd | frameErr;
  assign goodEnd   = state_q[2] && frameEnd && !frameErr;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (idValid) begin
          state_d = ST_WALK;
        end
      end
      ST_WALK: begin
        if (frameDone) begin
          state_d = ST_IDLE;
        end else if (decide) begin
          state_d = (decTgt == TGT_NONE) ? ST_DROP : ST_STORE;
        end
      end
      ST_STORE, ST_DROP: begin
        if (frameDone) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    newData_d = newData_q;
    if (wrEn && wordAddr == REG_NEW_DATA[7:2]) begin
      newData_d = newData_q & ~(writedata & wrMask);
    end
    if (goodEnd && tgt_q == TGT_RXBUF) begin
      newData_d[bufIdx_q] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitReq_q  <= 1'b1;
      readData_q <= 32'h0000_0000;
    end else begin
      waitReq_q <= ~(busReq & waitReq_q);
      if (busReq && waitReq_q) begin
        readData_q <= rdMux;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      globalFilterConfig_q   <= GLOBAL_CFG_RST;
      stdListConfig_q        <= LIST_CFG_RST;
      extListConfig_q        <= LIST_CFG_RST;
      extIdentifierAndMask_q <= EXT_MASK_RST;
      stdElem_q              <= '{default: ELEM_RST};
      extElem_q              <= '{default: ELEM_RST};
    end else if (wrEn) begin
      if (wordAddr == REG_GLOBAL_CFG[7:2] && byteenable[0]) begin
        globalFilterConfig_q <= writedata[3:0];
      end
      if (wordAddr == REG_STD_LIST[7:2] && byteenable[0]) begin
        stdListConfig_q <= writedata[3:0];
      end
      if (wordAddr == REG_EXT_LIST[7:2] && byteenable[0]) begin
        extListConfig_q <= writedata[3:0];
      end
      if (wordAddr == REG_EXT_MASK[7:2]) begin
        extIdentifierAndMask_q <= (extIdentifierAndMask_q & ~wrMask[28:0]) |
                                  (writedata[28:0] & wrMask[28:0]);
      end
      if (selStd) begin
        stdElem_q[address[4:2]] <= (stdElem_q[address[4:2]] & ~wrMask) | (writedata & wrMask);
      end
      if (selExt) begin
        extElem_q[address[5:2]] <= (extElem_q[address[5:2]] & ~wrMask) | (writedata & wrMask);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      newData_q                <= '0;
      hpm_q                    <= 1'b0;
      lastErrorCode_q          <= LEC_RST;
      dataPhaseLastErrorCode_q <= LEC_RST;
    end else begin
      newData_q <= newData_d;
      if (setHpm) begin
        hpm_q <= 1'b1;
      end else if (wrEn && wordAddr == REG_STATUS[7:2] && byteenable[1] && writedata[ST_HPM]) begin
        hpm_q <= 1'b0;
      end
      if (frameErr && !dataPhaseErr) begin
        lastErrorCode_q <= errCode;
      end
      if (frameErr && dataPhaseErr) begin
        dataPhaseLastErrorCode_q <= errCode;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= ST_IDLE;
      frame_q   <= '0;
      elemIdx_q <= 4'h0;
      tgt_q     <= TGT_NONE;
      bufIdx_q  <= 5'h00;
      busy_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= state_d != ST_IDLE;
      if (state_q[0] && idValid) begin
        frame_q   <= rxFrame;
        elemIdx_q <= 4'h0;
      end else if (state_q[1] && !decide) begin
        elemIdx_q <= elemIdx_q + 4'h1;
      end
      if (decide) begin
        tgt_q    <= decTgt;
        bufIdx_q <= elemBuf;
      end
    end
  end

  // header word carries the raw identifier, then payload words follow
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramWrite_q <= '0;
      word_q     <= 5'h00;
      put0_q     <= 1'b0;
      put1_q     <= 1'b0;
      event_q    <= 1'b0;
    end else begin
      ramWrite_q.we <= 1'b0;
      if (decide && decTgt != TGT_NONE && !frameDone) begin
        ramWrite_q <= '{we: 1'b1, kind: decTgt, bufIdx: elemBuf, word: 5'h00,
                        data: {frame_q.rtr, frame_q.ide, 1'b0, frame_q.id}};
        word_q     <= 5'h01;
      end else if (state_q[2] && dataValid && !frameDone) begin
        ramWrite_q <= '{we: 1'b1, kind: tgt_q, bufIdx: bufIdx_q, word: word_q,
                        data: dataWord};
        word_q     <= word_q + 5'h01;
      end
      put0_q  <= goodEnd && tgt_q == TGT_FIFO0;
      put1_q  <= goodEnd && tgt_q == TGT_FIFO1;
      event_q <= decide && elemHit && action == ACT_RXBUF && idTwo[EVENT_BIT];
    end
  end

  assign readdata            = readData_q;
  assign waitrequest         = waitReq_q;
  assign ramWrite            = ramWrite_q;
  assign fifoPut0            = put0_q;
  assign fifoPut1            = put1_q;
  assign filterEvent         = event_q;
  assign highPriorityMsgFlag = hpm_q;
  assign busy                = busy_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_walk_from_zero: assert property (
      state_q[0] && idValid |=> state_q[1] && elemIdx_q == 4'h0)
    else $error("walk did not start at element zero");
  chk_stop_first_hit: assert property (state_q[1] && elemHit && !frameDone |=> !state_q[1])
    else $error("walk went on after a match");
  chk_disabled_dead: assert property (action == ACT_DISABLED |-> !elemHit)
    else $error("disabled element matched");
  chk_locked_buffer: assert property (
      action == ACT_RXBUF && newData_q[elemBuf] |-> !elemHit)
    else $error("locked rx buffer matched");
  chk_header_raw: assert property (
      decide && decTgt != TGT_NONE && !frameDone |=> ramWrite_q.we &&
      ramWrite_q.word == 5'h00 && ramWrite_q.data[28:0] == $past(frame_q.id))
    else $error("header word lost the raw identifier");
  chk_error_no_commit: assert property (state_q[2] && frameErr
      |=> !fifoPut0 && !fifoPut1 && (newData_q & ~$past(newData_q)) == '0)
    else $error("errored frame was committed");
  chk_error_code: assert property (frameErr && !dataPhaseErr
      |=> lastErrorCode_q == $past(errCode))
    else $error("last error code not captured");
  chk_hpm_sets: assert property (setHpm |=> highPriorityMsgFlag)
    else $error("high priority flag not set");
  chk_no_match_drop: assert property (
      state_q[1] && listEnd && !frameDone && decTgt == TGT_NONE
      |=> state_q[3] ##1 !ramWrite_q.we)
    else $error("unmatched frame not dropped");
  chk_bus_one_wait: assert property (busReq && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait cycle");
endmodule : can_rx_acceptance_filter
`default_nettype wire

// File: hw/can_rx_filter_pkg.sv
// types, register map and constants of the rx acceptance filter
`default_nettype none
package can_rx_filter_pkg;
  localparam int unsigned STD_ELEMS = 8;
  localparam int unsigned EXT_ELEMS = 8;
  localparam int unsigned RX_BUFS   = 32;

  localparam logic [7:0] REG_GLOBAL_CFG = 8'h00;
  localparam logic [7:0] REG_STD_LIST   = 8'h04;
  localparam logic [7:0] REG_EXT_LIST   = 8'h08;
  localparam logic [7:0] REG_EXT_MASK   = 8'h0C;
  localparam logic [7:0] REG_STATUS     = 8'h10;
  localparam logic [7:0] REG_NEW_DATA   = 8'h14;
  localparam logic [2:0] STD_ELEM_BASE  = 3'h2;
  localparam logic [1:0] EXT_ELEM_BASE  = 2'h2;

  localparam logic [3:0]  GLOBAL_CFG_RST = 4'h0;
  localparam logic [3:0]  LIST_CFG_RST   = 4'h0;
  localparam logic [28:0] EXT_MASK_RST   = 29'h1FFF_FFFF;
  localparam logic [31:0] ELEM_RST       = 32'h0000_0000;
  localparam logic [2:0]  LEC_RST        = 3'h0;

  localparam int unsigned ST_LEC     = 0;
  localparam int unsigned ST_DLEC    = 4;
  localparam int unsigned ST_HPM     = 8;
  localparam int unsigned ST_BUSY    = 9;
  localparam int unsigned STD_TYPE   = 30;
  localparam int unsigned STD_ACT    = 27;
  localparam int unsigned STD_ID1    = 16;
  localparam int unsigned EXT_ACT    = 29;
  localparam int unsigned EXT_TYPE   = 30;
  localparam int unsigned EVENT_BIT  = 9;
  localparam int unsigned NM_EXT     = 2;

  localparam logic [1:0] FT_RANGE     = 2'h0;
  localparam logic [1:0] FT_DUAL      = 2'h1;
  localparam logic [1:0] FT_CLASSIC   = 2'h2;
  localparam logic [1:0] FT_RANGE_RAW = 2'h3;
  localparam logic [1:0] NM_FIFO0     = 2'h0;
  localparam logic [1:0] NM_FIFO1     = 2'h1;

  typedef enum logic [2:0] {
    ACT_DISABLED = 3'h0, ACT_FIFO0 = 3'h1, ACT_FIFO1 = 3'h2, ACT_REJECT = 3'h3,
    ACT_HPM = 3'h4, ACT_HPM_FIFO0 = 3'h5, ACT_HPM_FIFO1 = 3'h6, ACT_RXBUF = 3'h7
  } act_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_WALK = 4'h2, ST_STORE = 4'h4, ST_DROP = 4'h8
  } state_t;

  typedef enum logic [1:0] {
    TGT_NONE = 2'h0, TGT_FIFO0 = 2'h1, TGT_FIFO1 = 2'h2, TGT_RXBUF = 2'h3
  } tgt_t;

  typedef struct packed {
    logic        ide;
    logic        rtr;
    logic [28:0] id;
  } rxFrame_t;

  typedef struct packed {
    logic        we;
    tgt_t        kind;
    logic [4:0]  bufIdx;
    logic [4:0]  word;
    logic [31:0] data;
  } ramWrite_t;

  function automatic logic [31:0] beMask(input logic [3:0] be);
    beMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : beMask
endpackage : can_rx_filter_pkg
`default_nettype wire

// File: hw/can_rx_elem_match.sv
// identifier comparison of one filter element
`default_nettype none
module can_rx_elem_match
  import can_rx_filter_pkg::*;
(
  input  wire logic [1:0]  filterType,
  input  wire logic        isExt,
  input  wire logic [28:0] idOne,
  input  wire logic [28:0] idTwo,
  input  wire logic [28:0] idMasked,
  input  wire logic [28:0] idRaw,
  output logic             hit
);
  logic [28:0] rangeId;
  logic        inRange;
  logic        dualHit;
  logic        maskHit;

  // only extended type 11 sees the unmasked id
  assign rangeId = (isExt && filterType == FT_RANGE_RAW) ? idRaw : idMasked;
  assign inRange = (rangeId >= idOne) && (rangeId <= idTwo);
  assign dualHit = (idMasked == idOne) || (idMasked == idTwo);
  assign maskHit = ((idMasked ^ idOne) & idTwo) == 29'h0000_0000;

  // standard type 11 is unused and never hits
  assign hit = (filterType == FT_RANGE)   ? inRange :
               (filterType == FT_DUAL)    ? dualHit :
               (filterType == FT_CLASSIC) ? maskHit :
               (isExt && inRange);
endmodule : can_rx_elem_match
`default_nettype wire

// File: test/can_engine_model.sv
// behavioural protocol engine: feeds frames and watches message ram writes
`default_nettype none
module can_engine_model
  import can_rx_filter_pkg::*;
(
  input  wire logic      clk,
  input  wire ramWrite_t ramWrite,
  input  wire logic      fifoPut0,
  input  wire logic      fifoPut1,
  input  wire logic      filterEvent,
  output logic           idValid,
  output rxFrame_t       rxFrame,
  output logic           dataValid,
  output logic    [31:0] dataWord,
  output logic           frameEnd,
  output logic           frameErr,
  output logic           dataPhaseErr,
  output logic     [2:0] errCode
);
  timeunit 1ns;
  timeprecision 100ps;

  int        hdrCnt;
  int        put0Cnt;
  int        put1Cnt;
  int        evtCnt;
  ramWrite_t hdr;
  ramWrite_t pay;

  initial begin
    idValid      = 1'b0;
    rxFrame      = '0;
    dataValid    = 1'b0;
    dataWord     = 32'h0000_0000;
    frameEnd     = 1'b0;
    frameErr     = 1'b0;
    dataPhaseErr = 1'b0;
    errCode      = 3'h0;
  end

  // counts restart with each identifier so every frame is judged alone
  always @(posedge clk) begin
    if (idValid) begin
      hdrCnt  = 0;
      put0Cnt = 0;
      put1Cnt = 0;
      evtCnt  = 0;
      pay     = '0;
    end else begin
      if (ramWrite.we && ramWrite.word == 5'h00) begin
        hdrCnt++;
        hdr = ramWrite;
      end
      if (ramWrite.we && ramWrite.word != 5'h00) begin
        pay = ramWrite;
      end
      put0Cnt += int'(fifoPut0);
      put1Cnt += int'(fifoPut1);
      evtCnt  += int'(filterEvent);
    end
  end

  // one whole frame; idle lines show the inverse so stale values never pass
  task automatic sendFrame(input rxFrame_t fr, input logic [31:0] w, input logic err,
                           input logic dph, input logic [2:0] code);
    @(posedge clk);
    idValid <= 1'b1;
    rxFrame <= fr;
    @(posedge clk);
    idValid <= 1'b0;
    rxFrame <= rxFrame_t'(~fr);
    // first word well after the header slot, or it would be lost
    repeat (12) @(posedge clk);
    dataValid <= 1'b1;
    dataWord  <= w;
    @(posedge clk);
    dataValid <= 1'b0;
    dataWord  <= ~w;
    repeat (3) @(posedge clk);
    frameEnd     <= ~err;
    frameErr     <= err;
    dataPhaseErr <= dph;
    errCode      <= code;
    @(posedge clk);
    frameEnd <= 1'b0;
    frameErr <= 1'b0;
    errCode  <= ~code;
    repeat (2) @(posedge clk);
  endtask : sendFrame
endmodule : can_engine_model
`default_nettype wire

// File: test/tb.sv
// self-checking bench of the rx acceptance filter
`default_nettype none
module tb
  import can_rx_filter_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin nMismatch++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

  typedef struct packed {
    rxFrame_t fr;
    tgt_t     kind;
    logic     p0;
    logic     p1;
    logic     hpm;
    logic     evt;
  } row_t;

  localparam row_t ROWS [10] = '{
    '{'{1'b0, 1'b0, 29'h0000_0101}, TGT_FIFO0, 1'b1, 1'b0, 1'b0, 1'b0},
    '{'{1'b0, 1'b1, 29'h0000_02FF}, TGT_FIFO1, 1'b0, 1'b1, 1'b0, 1'b0},
    '{'{1'b0, 1'b0, 29'h0000_030A}, TGT_NONE,  1'b0, 1'b0, 1'b0, 1'b0},
    '{'{1'b0, 1'b0, 29'h0000_0400}, TGT_NONE,  1'b0, 1'b0, 1'b1, 1'b0},
    '{'{1'b0, 1'b0, 29'h0000_0123}, TGT_RXBUF, 1'b0, 1'b0, 1'b0, 1'b1},
    '{'{1'b0, 1'b0, 29'h0000_0123}, TGT_NONE,  1'b0, 1'b0, 1'b1, 1'b0},
    '{'{1'b1, 1'b0, 29'h0123_45AB}, TGT_FIFO0, 1'b1, 1'b0, 1'b0, 1'b0},
    '{'{1'b1, 1'b0, 29'h0AAA_0015}, TGT_FIFO1, 1'b0, 1'b1, 1'b0, 1'b0},
    '{'{1'b1, 1'b0, 29'h0BBB_0042}, TGT_NONE,  1'b0, 1'b0, 1'b0, 1'b0},
    '{'{1'b1, 1'b0, 29'h0DDD_0000}, TGT_FIFO0, 1'b1, 1'b0, 1'b0, 1'b0}};

  logic        clk;
  logic        rst_b;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        idValid;
  rxFrame_t    rxFrame;
  logic        dataValid;
  logic [31:0] dataWord;
  logic        frameEnd;
  logic        frameErr;
  logic        dataPhaseErr;
  logic [2:0]  errCode;
  ramWrite_t   ramWrite;
  logic        fifoPut0;
  logic        fifoPut1;
  logic        filterEvent;
  logic        highPriorityMsgFlag;
  logic        busy;
  logic [31:0] rd;
  row_t        r;
  int          checks;
  int          nMismatch;
  logic [7:0]  cfgAddr [15];
  logic [31:0] cfgData [15];

  can_rx_acceptance_filter u_dut (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .idValid(idValid), .rxFrame(rxFrame),
    .dataValid(dataValid), .dataWord(dataWord), .frameEnd(frameEnd),
    .frameErr(frameErr), .dataPhaseErr(dataPhaseErr), .errCode(errCode),
    .ramWrite(ramWrite), .fifoPut0(fifoPut0), .fifoPut1(fifoPut1),
    .filterEvent(filterEvent), .highPriorityMsgFlag(highPriorityMsgFlag), .busy(busy));

  can_engine_model u_model (
    .clk(clk), .ramWrite(ramWrite), .fifoPut0(fifoPut0), .fifoPut1(fifoPut1),
    .filterEvent(filterEvent), .idValid(idValid), .rxFrame(rxFrame),
    .dataValid(dataValid), .dataWord(dataWord), .frameEnd(frameEnd),
    .frameErr(frameErr), .dataPhaseErr(dataPhaseErr), .errCode(errCode));

  always #5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // one avalon access; request held until waitrequest is sampled low
  task automatic busAccess(input logic [7:0] a, input logic wr, input logic [31:0] d,
                           input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= d;
    byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      nMismatch++;
      stop_test();
    end
  endtask : busAccess

  task automatic regCheck(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    busAccess(a, 1'b0, 32'h0000_0000, 4'hF, q);
    `CHK(q, exp)
  endtask : regCheck

  function automatic logic [31:0] stdElem(input logic [1:0] t, input act_t a,
                                          input logic [10:0] one, input logic [10:0] two);
    stdElem = {t, a, one, 5'h00, two};
  endfunction : stdElem

  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0000_0000;
    checks = 0;
    nMismatch = 0;
    // std non-match rejects, ext non-match goes to fifo 0
    cfgAddr = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54,
                8'h80, 8'h84, 8'h88, 8'h8C, 8'h90};
    cfgData = '{32'h0000_0002, 32'h0000_0006, 32'h0000_0003, 32'h1FFF_FF00,
                stdElem(FT_DUAL, ACT_FIFO0, 11'h100, 11'h101),
                stdElem(FT_RANGE, ACT_FIFO1, 11'h200, 11'h2FF),
                stdElem(FT_CLASSIC, ACT_REJECT, 11'h300, 11'h7F0),
                stdElem(FT_DUAL, ACT_DISABLED, 11'h400, 11'h400),
                stdElem(FT_DUAL, ACT_RXBUF, 11'h123, 11'h205),
                stdElem(FT_CLASSIC, ACT_HPM, 11'h000, 11'h000),
                {ACT_FIFO0, 29'h0123_4500}, {FT_RANGE, 1'b0, 29'h0123_45FF},
                {ACT_FIFO1, 29'h0AAA_0010}, {FT_RANGE_RAW, 1'b0, 29'h0AAA_0020},
                {ACT_REJECT, 29'h0BBB_0000}};
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    `CHK(busy, 1'b0)
    `CHK(waitrequest, 1'b1)
    regCheck(REG_EXT_MASK, 32'h1FFF_FFFF);
    regCheck(REG_STD_LIST, 32'h0000_0000);
    regCheck(REG_STATUS, 32'h0000_0000);
    regCheck(REG_NEW_DATA, 32'h0000_0000);
    regCheck(8'h40, 32'h0000_0000);
    busAccess(8'h3C, 1'b1, 32'hFFFF_FFFF, 4'hF, rd);
    regCheck(8'h3C, 32'h0000_0000);
    foreach (cfgAddr[i]) busAccess(cfgAddr[i], 1'b1, cfgData[i], 4'hF, rd);
    busAccess(8'h94, 1'b1, {FT_DUAL, 1'b0, 29'h0CCC_0000}, 4'hF, rd);
    regCheck(REG_EXT_MASK, 32'h1FFF_FF00);
    for (int i = 0; i < 10; i++) begin
      r = ROWS[i];
      u_model.sendFrame(r.fr, 32'hA5A5_0000 + i, 1'b0, 1'b0, 3'h0);
      `CHK(u_model.put0Cnt == 1, r.p0)
      `CHK(u_model.put1Cnt == 1, r.p1)
      `CHK(u_model.evtCnt == 1, r.evt)
      `CHK(highPriorityMsgFlag, r.hpm)
      `CHK(busy, 1'b0)
      if (r.kind != TGT_NONE) begin
        `CHK(u_model.hdr.kind, r.kind)
        `CHK(u_model.hdr.data, {r.fr.rtr, r.fr.ide, 1'b0, r.fr.id})
        `CHK(u_model.pay.word, 5'h01)
        `CHK(u_model.pay.data, 32'hA5A5_0000 + i)
      end else begin
        `CHK(u_model.hdrCnt == 0, 1'b1)
      end
      busAccess(REG_STATUS, 1'b1, 32'h0000_0100, 4'h2, rd);
    end
    // awkward cases: new data bit read and cleared, then errored frames to buffer and fifo
    regCheck(REG_NEW_DATA, 32'h0000_0020);
    busAccess(REG_NEW_DATA, 1'b1, 32'h0000_0020, 4'hF, rd);
    regCheck(REG_NEW_DATA, 32'h0000_0000);
    u_model.sendFrame(ROWS[4].fr, 32'h1234_5678, 1'b1, 1'b0, 3'h2);
    `CHK(u_model.hdr.bufIdx, 5'h05)
    regCheck(REG_NEW_DATA, 32'h0000_0000);
    regCheck(REG_STATUS, 32'h0000_0002);
    u_model.sendFrame(ROWS[0].fr, 32'h1234_5678, 1'b1, 1'b1, 3'h5);
    `CHK(u_model.put0Cnt == 0, 1'b1)
    `CHK(u_model.hdrCnt == 1, 1'b1)
    regCheck(REG_STATUS, 32'h0000_0052);
    // unmatched extended frame: fifo 1 first, then rejected
    busAccess(REG_GLOBAL_CFG, 1'b1, 32'h0000_0006, 4'h1, rd);
    u_model.sendFrame(ROWS[9].fr, 32'h0000_0001, 1'b0, 1'b0, 3'h0);
    `CHK(u_model.put1Cnt == 1, 1'b1)
    busAccess(REG_GLOBAL_CFG, 1'b1, 32'h0000_000A, 4'h1, rd);
    u_model.sendFrame(ROWS[9].fr, 32'h0000_0002, 1'b0, 1'b0, 3'h0);
    `CHK(u_model.hdrCnt == 0, 1'b1)
    `CHK(u_model.put0Cnt + u_model.put1Cnt, 0)
    // priority element that also stores in fifo 1
    busAccess(8'h54, 1'b1, stdElem(FT_CLASSIC, ACT_HPM_FIFO1, 11'h000, 11'h000), 4'hF, rd);
    u_model.sendFrame(ROWS[3].fr, 32'h0000_0003, 1'b0, 1'b0, 3'h0);
    `CHK(u_model.put1Cnt == 1, 1'b1)
    `CHK(highPriorityMsgFlag, 1'b1)
    stop_test();
  end
`undef CHK
endmodule : tb
`default_nettype wire
